// ===== easeg_regs.svh
// Constants for the effective address and segment select block.
// Assumes it is included by bare name from the block's package and modules.
`ifndef EASEG_REGS_SVH
`define EASEG_REGS_SVH

`define EASEG_ADDR_W 32
`define EASEG_SEL_W 16
`define EASEG_PORT_W 16
`define EASEG_FAR_OFF_LSB 0
`define EASEG_FAR_SEL_LSB 32
`define EASEG_FAR_W 48
`define EASEG_GPR_STACK_PTR 3'h4
`define EASEG_GPR_FRAME_PTR 3'h5
`define EASEG_SCALE_1 2'h0
`define EASEG_SCALE_2 2'h1
`define EASEG_SCALE_4 2'h2
`define EASEG_SCALE_8 2'h3
`define EASEG_SEG_RST 16'h0000

`endif

// ===== easeg_pkg.sv
// Types shared by the effective address and segment select modules.
// Assumes easeg_regs.svh sits in the same folder.
`default_nettype none
`include "easeg_regs.svh"
package easeg_pkg;
	typedef enum logic [2:0] {
		EASEG_SEG_CODE,
		EASEG_SEG_STACK,
		EASEG_SEG_DATA,
		EASEG_SEG_STRDST,
		EASEG_SEG_EXTRA_F,
		EASEG_SEG_EXTRA_G
	} easeg_seg_t;
	typedef enum logic [2:0] {
		EASEG_REF_FETCH,
		EASEG_REF_DATA,
		EASEG_REF_PUSHPOP,
		EASEG_REF_STRDST,
		EASEG_REF_FARPTR,
		EASEG_REF_IO,
		EASEG_REF_SYSREG,
		EASEG_REF_PAIR
	} easeg_ref_t;
	typedef enum logic [1:0] {
		EASEG_DISP_NONE,
		EASEG_DISP_8,
		EASEG_DISP_16,
		EASEG_DISP_32
	} easeg_disp_t;
	typedef enum logic {
		EASEG_ST_IDLE,
		EASEG_ST_DONE
	} easeg_state_t;
endpackage
`default_nettype wire

// ===== easeg_sum_if.sv
// Carries address components from the top module to the adder module.
// Assumes a single clock domain; purely combinational signals.
`default_nettype none
`include "easeg_regs.svh"
interface easeg_sum_if;
	logic [`EASEG_ADDR_W-1:0] disp;
	logic [`EASEG_ADDR_W-1:0] base;
	logic [`EASEG_ADDR_W-1:0] index;
	logic [1:0] scale;
	logic base_use;
	logic index_use;
	logic size16;
	logic [`EASEG_ADDR_W-1:0] sum;
	modport src (output disp, base, index, scale, base_use, index_use, size16, input sum);
	modport adder (input disp, base, index, scale, base_use, index_use, size16, output sum);
endinterface
`default_nettype wire

// ===== easeg_adder.sv
// Effective address adder: displacement plus base plus scaled index.
// Assumes the displacement arrives already sign extended to full width.
`default_nettype none
`include "easeg_regs.svh"
module easeg_adder (
	easeg_sum_if.adder bus
);
	logic [`EASEG_ADDR_W-1:0] base_term;
	logic [`EASEG_ADDR_W-1:0] index_term;
	logic [`EASEG_ADDR_W-1:0] raw;
	always_comb begin
		base_term = bus.base_use ? bus.base : 32'h00000000;
		index_term = 32'h00000000;
		if (bus.index_use) begin
			// Shift keeps two's complement wrap, so a negative index scales correctly.
			index_term = bus.index << bus.scale;
		end
		raw = bus.disp + base_term + index_term;
		if (bus.size16) begin
			bus.sum = {16'h0000, raw[15:0]};
		end else begin
			bus.sum = raw;
		end
	end
endmodule
`default_nettype wire

// ===== easeg_seg_pick.sv
// Segment chooser: default segment per reference kind plus override handling.
// Assumes a valid override code only when the prefix byte was decoded.
`default_nettype none
`include "easeg_regs.svh"
module easeg_seg_pick (
	input wire easeg_pkg::easeg_ref_t ref_kind_in,
	input wire logic base_use_in,
	input wire logic [2:0] base_sel_in,
	input wire logic ovr_valid_in,
	input wire easeg_pkg::easeg_seg_t ovr_seg_in,
	output easeg_pkg::easeg_seg_t seg_out
);
	logic stack_base;
	assign stack_base = base_use_in && (base_sel_in == `EASEG_GPR_STACK_PTR
		|| base_sel_in == `EASEG_GPR_FRAME_PTR);
	always_comb begin
		case (ref_kind_in)
			easeg_pkg::EASEG_REF_FETCH: seg_out = easeg_pkg::EASEG_SEG_CODE;
			easeg_pkg::EASEG_REF_PUSHPOP: seg_out = easeg_pkg::EASEG_SEG_STACK;
			easeg_pkg::EASEG_REF_STRDST: seg_out = easeg_pkg::EASEG_SEG_STRDST;
			easeg_pkg::EASEG_REF_DATA, easeg_pkg::EASEG_REF_FARPTR,
			easeg_pkg::EASEG_REF_PAIR: begin
				if (ovr_valid_in) begin
					seg_out = ovr_seg_in;
				end else if (stack_base) begin
					seg_out = easeg_pkg::EASEG_SEG_STACK;
				end else begin
					seg_out = easeg_pkg::EASEG_SEG_DATA;
				end
			end
			default: seg_out = easeg_pkg::EASEG_SEG_DATA;
		endcase
	end
endmodule
`default_nettype wire

// ===== easeg_top.sv
// Operand address generation: effective address, segment, far pointer,
// register pair quadword, I/O port number and implied system register.
// Assumes decoded fields and register values are held steady with req_in.
`default_nettype none
`include "easeg_regs.svh"
module easeg_top (
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic req_in,
	input wire easeg_pkg::easeg_ref_t ref_kind_in,
	input wire easeg_pkg::easeg_disp_t disp_kind_in,
	input wire logic [31:0] disp_in,
	input wire logic base_use_in,
	input wire logic [2:0] base_sel_in,
	input wire logic [31:0] base_val_in,
	input wire logic index_use_in,
	input wire logic [2:0] index_sel_in,
	input wire logic [31:0] index_val_in,
	input wire logic [1:0] scale_in,
	input wire logic addr16_in,
	input wire logic ovr_valid_in,
	input wire easeg_pkg::easeg_seg_t ovr_seg_in,
	input wire logic sel_from_mem_in,
	input wire logic [15:0] sel_mem_in,
	input wire logic [15:0] sel_reg_in,
	input wire logic [47:0] far_ptr_in,
	input wire logic [31:0] pair_high_reg_in,
	input wire logic [31:0] pair_low_reg_in,
	input wire logic port_from_imm_in,
	input wire logic [7:0] port_imm_in,
	input wire logic [15:0] port_index_reg_in,
	input wire logic [1:0] port_width_in,
	input wire logic [3:0] sysreg_code_in,
	output logic done_out,
	output logic fault_out,
	output easeg_pkg::easeg_seg_t seg_out,
	output logic [31:0] offset_out,
	output logic [15:0] selector_out,
	output logic [63:0] quad_out,
	output logic [15:0] port_out,
	output logic [1:0] port_width_out,
	output logic [3:0] sysreg_sel_out
);
	easeg_sum_if sum_bus ();
	easeg_pkg::easeg_seg_t seg_pick;
	easeg_pkg::easeg_state_t state_reg;
	easeg_pkg::easeg_state_t state_next;
	easeg_pkg::easeg_seg_t seg_next;
	logic done_next;
	logic fault_next;
	logic [31:0] offset_next;
	logic [15:0] selector_next;
	logic [63:0] quad_next;
	logic [15:0] port_next;
	logic [1:0] port_width_next;
	logic [3:0] sysreg_sel_next;
	logic data_ref;
	logic far_ref;
	logic pair_ref;
	logic io_ref;
	logic sys_ref;
	logic [15:0] port_imm_ext;
	logic [15:0] explicit_sel;
	logic sp_index;
	logic orphan_scale;
	logic [31:0] disp_ext;
	logic illegal;

	// Displacement is sign extended from its encoded width.
	always_comb begin
		case (disp_kind_in)
			easeg_pkg::EASEG_DISP_8: disp_ext = {{24{disp_in[7]}}, disp_in[7:0]};
			easeg_pkg::EASEG_DISP_16: disp_ext = {{16{disp_in[15]}}, disp_in[15:0]};
			easeg_pkg::EASEG_DISP_32: begin
				// A 32-bit displacement cannot exist under 16-bit addressing.
				disp_ext = addr16_in ? {{16{disp_in[15]}}, disp_in[15:0]} : disp_in;
			end
			default: disp_ext = 32'h00000000;
		endcase
	end

	// A scale without index, or the stack pointer as index, is refused.
	always_comb begin
		sp_index = 1'b0;
		orphan_scale = 1'b0;
		if (index_use_in) begin
			if (index_sel_in == `EASEG_GPR_STACK_PTR) begin
				sp_index = 1'b1;
			end
		end else if (scale_in != `EASEG_SCALE_1) begin
			orphan_scale = 1'b1;
		end
		illegal = sp_index || orphan_scale;
	end

	assign sum_bus.disp = disp_ext;
	assign sum_bus.base = base_val_in;
	assign sum_bus.index = index_val_in;
	assign sum_bus.scale = scale_in;
	assign sum_bus.base_use = base_use_in;
	assign sum_bus.index_use = index_use_in;
	assign sum_bus.size16 = addr16_in;

	easeg_adder u_adder (
		.bus(sum_bus)
	);

	easeg_seg_pick u_seg (
		.ref_kind_in(ref_kind_in),
		.base_use_in(base_use_in),
		.base_sel_in(base_sel_in),
		.ovr_valid_in(ovr_valid_in),
		.ovr_seg_in(ovr_seg_in),
		.seg_out(seg_pick)
	);

	// Request strobes per reference kind; pair, port, width and system register results are left alone by other kinds.
	always_comb begin
		data_ref = 1'b0;
		far_ref = 1'b0;
		pair_ref = 1'b0;
		io_ref = 1'b0;
		sys_ref = 1'b0;
		if (req_in) begin
			case (ref_kind_in)
				easeg_pkg::EASEG_REF_DATA: data_ref = 1'b1;
				easeg_pkg::EASEG_REF_FARPTR: far_ref = 1'b1;
				easeg_pkg::EASEG_REF_PAIR: pair_ref = 1'b1;
				easeg_pkg::EASEG_REF_IO: io_ref = 1'b1;
				easeg_pkg::EASEG_REF_SYSREG: sys_ref = 1'b1;
				default: data_ref = 1'b0;
			endcase
		end
	end

	// Handshake state: one answer cycle follows every request cycle.
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			easeg_pkg::EASEG_ST_IDLE: begin
				if (req_in) begin
					state_next = easeg_pkg::EASEG_ST_DONE;
				end
			end
			easeg_pkg::EASEG_ST_DONE: begin
				if (!req_in) begin
					state_next = easeg_pkg::EASEG_ST_IDLE;
				end
			end
			default: state_next = easeg_pkg::EASEG_ST_IDLE;
		endcase
	end

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_reg <= easeg_pkg::EASEG_ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// Back-to-back requests keep the state in DONE, so done stays high for each one.
	// There is no wait state: the answer is always ready on the next edge.
	always_comb begin
		done_next = state_next == easeg_pkg::EASEG_ST_DONE;
	end

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			done_out <= 1'b0;
		end else begin
			done_out <= done_next;
		end
	end

	// Only data references carry the address check; other kinds never fault.
	always_comb begin
		fault_next = data_ref && illegal;
	end

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			fault_out <= 1'b0;
		end else begin
			fault_out <= fault_next;
		end
	end

	// The segment answer follows every request and otherwise stands.
	always_comb begin
		seg_next = seg_out;
		if (req_in) begin
			seg_next = seg_pick;
		end
	end

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			seg_out <= easeg_pkg::EASEG_SEG_DATA;
		end else begin
			seg_out <= seg_next;
		end
	end

	// A refused address reads as zero, so no stray access can be made with it.
	// The far pointer offset bypasses the adder since it is already complete.
	always_comb begin
		offset_next = offset_out;
		if (far_ref) begin
			offset_next = far_ptr_in[`EASEG_FAR_OFF_LSB +: 32];
		end else if (req_in && illegal) begin
			offset_next = 32'h00000000;
		end else if (req_in) begin
			offset_next = sum_bus.sum;
		end
	end

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			offset_out <= 32'h00000000;
		end else begin
			offset_out <= offset_next;
		end
	end

	// Source of an explicit selector, used whenever no far pointer supplies one.
	always_comb begin
		explicit_sel = sel_reg_in;
		if (sel_from_mem_in) begin
			explicit_sel = sel_mem_in;
		end
	end

	// A far pointer carries its selector in the word above the offset.
	always_comb begin
		selector_next = selector_out;
		if (far_ref) begin
			selector_next = far_ptr_in[`EASEG_FAR_SEL_LSB +: 16];
		end else if (req_in) begin
			selector_next = explicit_sel;
		end
	end

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			selector_out <= `EASEG_SEG_RST;
		end else begin
			selector_out <= selector_next;
		end
	end

	// Register pair quadword assembly: the first named register is the upper half.
	always_comb begin
		quad_next = quad_out;
		if (pair_ref) begin
			quad_next = {pair_high_reg_in, pair_low_reg_in};
		end
	end

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			quad_out <= 64'h0000000000000000;
		end else begin
			quad_out <= quad_next;
		end
	end

	// The immediate form reaches only the first 256 ports.
	always_comb begin
		port_imm_ext = {8'h00, port_imm_in};
	end

	// Port number from the immediate or from the port index register.
	always_comb begin
		port_next = port_out;
		if (io_ref) begin
			if (port_from_imm_in) begin
				port_next = port_imm_ext;
			end else begin
				port_next = port_index_reg_in;
			end
		end
	end

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			port_out <= 16'h0000;
		end else begin
			port_out <= port_next;
		end
	end

	// The width code is passed through; the access logic splits wide ports.
	always_comb begin
		port_width_next = port_width_out;
		if (io_ref) begin
			port_width_next = port_width_in;
		end
	end

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			port_width_out <= 2'h0;
		end else begin
			port_width_out <= port_width_next;
		end
	end

	// The system register comes from the opcode's implied code, never an operand field.
	always_comb begin
		sysreg_sel_next = sysreg_sel_out;
		if (sys_ref) begin
			sysreg_sel_next = sysreg_code_in;
		end
	end

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sysreg_sel_out <= 4'h0;
		end else begin
			sysreg_sel_out <= sysreg_sel_next;
		end
	end
endmodule
`default_nettype wire

// ===== easeg_props.sv
// Checker for the address and segment block, watching top ports only.
// Assumes the bench binds it to easeg_top.
`default_nettype none
module easeg_props (
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic req_in,
	input wire easeg_pkg::easeg_ref_t ref_kind_in,
	input wire logic base_use_in,
	input wire logic [2:0] base_sel_in,
	input wire logic index_use_in,
	input wire logic [2:0] index_sel_in,
	input wire logic [1:0] scale_in,
	input wire logic ovr_valid_in,
	input wire easeg_pkg::easeg_seg_t ovr_seg_in,
	input wire logic done_out,
	input wire logic fault_out,
	input wire easeg_pkg::easeg_seg_t seg_out,
	input wire logic [31:0] offset_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clock_in); endclocking
	default disable iff (!rst_n_in);
	logic dreq;
	assign dreq = req_in && ref_kind_in == easeg_pkg::EASEG_REF_DATA;
	a_done_follows_req: assert property (req_in |=> done_out) else $error("done missing");
	a_done_idle: assert property (!req_in |=> !done_out) else $error("done without request");
	a_fetch_code_seg: assert property (req_in && ref_kind_in == easeg_pkg::EASEG_REF_FETCH
		|=> seg_out == easeg_pkg::EASEG_SEG_CODE) else $error("fetch segment wrong");
	a_push_stack_seg: assert property (req_in && ref_kind_in == easeg_pkg::EASEG_REF_PUSHPOP
		|=> seg_out == easeg_pkg::EASEG_SEG_STACK) else $error("stack segment wrong");
	a_strdst_seg: assert property (req_in && ref_kind_in == easeg_pkg::EASEG_REF_STRDST
		|=> seg_out == easeg_pkg::EASEG_SEG_STRDST) else $error("string segment wrong");
	a_default_data_seg: assert property (dreq && !ovr_valid_in |=> seg_out ==
		($past(base_use_in) && $past(base_sel_in[2:1]) == 2'h2 ?
		easeg_pkg::EASEG_SEG_STACK : easeg_pkg::EASEG_SEG_DATA)) else $error("default seg");
	a_override_seg: assert property (dreq && ovr_valid_in |=> seg_out == $past(ovr_seg_in))
		else $error("override ignored");
	a_sp_index_fault: assert property (dreq && index_use_in && index_sel_in == 3'h4
		|=> fault_out && offset_out == 32'h0) else $error("stack index accepted");
	a_scale_no_index: assert property (dreq && !index_use_in && scale_in != 2'h0
		|=> fault_out) else $error("scale without index accepted");
	c_override: cover property (dreq && ovr_valid_in);
	c_fault: cover property (fault_out);
	c_back_to_back: cover property (req_in ##1 req_in);
endmodule
`default_nettype wire

// ===== easeg_sink.sv
// Access logic model: counts the answers the block hands on.
// Assumes done_in is a one-cycle pulse per answer.
`default_nettype none
module easeg_sink (
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic done_in,
	output var int count_out
);
	timeunit 1ns;
	timeprecision 1ps;
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			count_out <= 0;
		end else if (done_in) begin
			count_out <= count_out + 1;
		end
	end
endmodule
`default_nettype wire

// ===== effective_address_segment_select_test.sv
// Random self-checking bench for easeg_top, with a few directed corners.
// Assumes the design files, easeg_props and easeg_sink are compiled first.
`default_nettype none
module effective_address_segment_select_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock_in, rst_n_in, req, b_use, i_use, a16, ovr, sfm, pfi, done, flt, pv, eflt;
	logic [2:0] b_sel, i_sel;
	logic [1:0] scl, pw, pwo, epw;
	logic [31:0] disp, bval, ival, hi, lo, off, eoff, seed;
	logic [15:0] smem, sreg, pidx, sel, port, esel, eport;
	logic [47:0] far;
	logic [63:0] quad, equad;
	logic [7:0] pimm;
	logic [3:0] sys, syso, esys;
	easeg_pkg::easeg_ref_t kind, pk;
	easeg_pkg::easeg_disp_t dk;
	easeg_pkg::easeg_seg_t oseg, seg, eseg;
	int fail_count, checks, cycles, nreq, cnt;
	easeg_top u_dut (.clock_in(clock_in), .rst_n_in(rst_n_in), .req_in(req),
		.ref_kind_in(kind), .disp_kind_in(dk), .disp_in(disp), .base_use_in(b_use),
		.base_sel_in(b_sel), .base_val_in(bval), .index_use_in(i_use), .index_sel_in(i_sel),
		.index_val_in(ival), .scale_in(scl), .addr16_in(a16), .ovr_valid_in(ovr),
		.ovr_seg_in(oseg), .sel_from_mem_in(sfm), .sel_mem_in(smem), .sel_reg_in(sreg),
		.far_ptr_in(far), .pair_high_reg_in(hi), .pair_low_reg_in(lo),
		.port_from_imm_in(pfi), .port_imm_in(pimm), .port_index_reg_in(pidx),
		.port_width_in(pw), .sysreg_code_in(sys), .done_out(done), .fault_out(flt),
		.seg_out(seg), .offset_out(off), .selector_out(sel), .quad_out(quad),
		.port_out(port), .port_width_out(pwo), .sysreg_sel_out(syso));
	easeg_sink u_sink (.clock_in(clock_in), .rst_n_in(rst_n_in), .done_in(done), .count_out(cnt));
	function automatic logic [32:0] exp_ea();
		logic [31:0] s;
		s = dk == easeg_pkg::EASEG_DISP_8 ? {{24{disp[7]}}, disp[7:0]} :
			dk == easeg_pkg::EASEG_DISP_16 ? {{16{disp[15]}}, disp[15:0]} :
			dk == easeg_pkg::EASEG_DISP_32 ? disp : 32'h0;
		s = s + (b_use ? bval : 32'h0) + (i_use ? ival << scl : 32'h0);
		if (a16) s = {16'h0, s[15:0]};
		if ((i_use && i_sel == 3'h4) || (!i_use && scl != 2'h0)) return {1'b1, 32'h0};
		return {1'b0, s};
	endfunction
	function automatic easeg_pkg::easeg_seg_t exp_seg();
		if (kind == easeg_pkg::EASEG_REF_FETCH) return easeg_pkg::EASEG_SEG_CODE;
		if (kind == easeg_pkg::EASEG_REF_PUSHPOP) return easeg_pkg::EASEG_SEG_STACK;
		if (kind == easeg_pkg::EASEG_REF_STRDST) return easeg_pkg::EASEG_SEG_STRDST;
		if (ovr) return oseg;
		if (b_use && b_sel[2:1] == 2'h2) return easeg_pkg::EASEG_SEG_STACK;
		return easeg_pkg::EASEG_SEG_DATA;
	endfunction
	task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		checks++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		clock_in = 1'b0;
		forever #5 clock_in = ~clock_in;
	end
	// A hang past this many cycles means the main sequence stopped making progress.
	always @(posedge clock_in) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			fail_count++;
			finish_test();
		end
	end
	initial begin
		{rst_n_in, req, b_use, i_use, a16, ovr, sfm, pfi, pv, b_sel, i_sel, scl, pw} = '0;
		{disp, bval, ival, hi, lo, smem, sreg, pidx, far, pimm, sys} = '0;
		{fail_count, checks, cycles, nreq} = '0;
		kind = easeg_pkg::EASEG_REF_FETCH;
		dk = easeg_pkg::EASEG_DISP_NONE;
		oseg = easeg_pkg::EASEG_SEG_CODE;
		seed = 32'hD451;
		repeat (10) @(posedge clock_in);
		#1 rst_n_in = 1'b1;
		for (int i = 0; i < 600; i++) begin
			@(posedge clock_in);
			#1;
			chk("done_out", pv, done);
			if (pv) begin
				chk("fault_out", eflt, flt);
				if (pk != easeg_pkg::EASEG_REF_IO && pk != easeg_pkg::EASEG_REF_SYSREG)
					chk("seg_out", eseg, seg);
				chk("offset_out", eoff, off);
				chk("selector_out", esel, sel);
				if (pk == easeg_pkg::EASEG_REF_PAIR) chk("quad_out", equad, quad);
				if (pk == easeg_pkg::EASEG_REF_IO) chk("port_out", {eport, epw}, {port, pwo});
				if (pk == easeg_pkg::EASEG_REF_SYSREG) chk("sysreg_sel_out", esys, syso);
			end
			req = ($random(seed) & 3) != 0;
			kind = easeg_pkg::easeg_ref_t'(3'($random(seed)));
			dk = easeg_pkg::easeg_disp_t'(2'($random(seed)));
			oseg = easeg_pkg::easeg_seg_t'(3'($unsigned($random(seed)) % 6));
			{b_use, i_use, a16, ovr, sfm, pfi, b_sel, i_sel, scl, pw} = 16'($random(seed));
			{disp, bval, ival, hi, lo} = {$random(seed), $random(seed), $random(seed),
				$random(seed), $random(seed)};
			{far, smem} = {$random(seed), $random(seed)};
			{sreg, pidx, pimm, sys} = 44'({$random(seed), $random(seed)});
			// Wrap past the top of the address space, then the same in 16-bit size.
			if (i < 2) begin
				kind = easeg_pkg::EASEG_REF_DATA;
				dk = easeg_pkg::EASEG_DISP_8;
				{req, disp, bval} = {1'b1, 32'h0000_0080, 32'hFFFF_FFFF};
				{b_use, i_use, ovr, a16, b_sel, scl} = {3'h4, 1'(i), 3'h5, 2'h0};
			end
			// The stack pointer offered as index must be refused.
			if (i == 2) begin
				{req, i_use, i_sel} = {1'b1, 1'b1, 3'h4};
				kind = easeg_pkg::EASEG_REF_DATA;
			end
			nreq += int'(req);
			pv = req;
			pk = kind;
			{eflt, eoff} = exp_ea();
			eflt = eflt && kind == easeg_pkg::EASEG_REF_DATA;
			if (kind == easeg_pkg::EASEG_REF_FARPTR) eoff = far[31:0];
			{eseg, equad, epw, esys} = {exp_seg(), hi, lo, pw, sys};
			esel = kind == easeg_pkg::EASEG_REF_FARPTR ? far[47:32] : (sfm ? smem : sreg);
			eport = pfi ? {8'h00, pimm} : pidx;
		end
		@(posedge clock_in);
		#1 chk("done_out", pv, done);
		req = 1'b0;
		repeat (3) @(posedge clock_in);
		#1 chk("done_count", nreq, cnt);
		finish_test();
	end
endmodule
bind easeg_top easeg_props u_props (.clock_in(clock_in), .rst_n_in(rst_n_in), .req_in(req_in),
	.ref_kind_in(ref_kind_in), .base_use_in(base_use_in), .base_sel_in(base_sel_in),
	.index_use_in(index_use_in), .index_sel_in(index_sel_in), .scale_in(scale_in),
	.ovr_valid_in(ovr_valid_in), .ovr_seg_in(ovr_seg_in), .done_out(done_out),
	.fault_out(fault_out), .seg_out(seg_out), .offset_out(offset_out));
`default_nettype wire
